//--- logic/pmwd_core.v
`timescale 1ns/1ps
`include "pmwd_map.vh"
// Behaviour
// R1 - idle-setting instruction is last before idle
// R2 - idle gates cpu clock, peripherals keep running
// R3 - idle holds registers, ports; ale/program_store_enable_pin high
// R4 - enabled interrupt clears idle bit, resumes
// R5 - two general flags kept for software
// R6 - reset ends idle after two cycles
// R7 - power-down stops oscillator, state retained
// R8 - power-down left by reset or interrupt
// R9 - only enabled external interrupts wake
// R10 - low restarts oscillator, release completes exit
// R11 - resume after power-down entering instruction
// R12 - agent holds wake until oscillator stable
// R13 - 14-bit watchdog disabled out of reset
// R14 - ordered key pair at 0A6h arms watchdog
// R15 - counts per machine cycle, no software disable
// R16 - key pair restarts; 3FFFh overflow resets
// R17 - overflow drives 96-period high reset pulse
// R18 - service register write-only, counter hidden
// R19 - software services within 16383 cycles
// R20 - 2^7 prescaler controlled at 0A7h
// R21 - power-down bit position is a parameter
// R22 - select field picks prescaler stages
module pmwd_core #(
  parameter PD_BIT = `PMWD_BIT_PDOWN,
  parameter WD_WIDTH = `PMWD_WD_WIDTH,
  parameter OSC_PER_MC = `PMWD_OSC_PER_MC,
  parameter PULSE_OSC = `PMWD_RST_PULSE_OSC,
  parameter HOLD_MC = `PMWD_RST_HOLD_MC,
  parameter PRESC_BITS = `PMWD_PRESC_BITS
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire instr_retire,
  input wire irq_pending,
  input wire [1:0] ext_irq_enable,
  input wire ext_irq_zero_high_prio,
  input wire ext_irq_zero_pin,
  input wire ext_irq_one_pin,
  input wire reset_pin_in,
  output reg [7:0] sfr_rdata,
  output reg sfr_rvalid,
  output reg cpu_clk_en,
  output reg periph_clk_en,
  output reg osc_run,
  output reg hold_state,
  output reg ale_force_high,
  output reg program_store_enable_pin_high,
  output reg wake_vector_one,
  output reg wake_irq,
  output reg device_reset,
  output reg reset_pin_out,
  output reg reset_pin_oe,
  output reg idle_active,
  output reg pdown_active
);
  // ----------------------------------------------------------
  // constants and helpers
  // ----------------------------------------------------------
  localparam ST_RUN = 2'd0;
  localparam ST_IDLE = 2'd1;
  localparam ST_PDOWN = 2'd2;
  localparam ST_WAKE = 2'd3;
  localparam PULSE_CYC = PULSE_OSC;
  localparam MC_W = 4;
  localparam PS_W = 8;
  localparam [MC_W-1:0] MC_LAST = OSC_PER_MC - 1;
  localparam [7:0] HOLD_CYC = HOLD_MC * OSC_PER_MC;
  localparam [7:0] PULSE_LAST = PULSE_CYC - 1;
  localparam [3:0] PS_MAX = PRESC_BITS;
  // overflow point is the all-ones count of the counter width
  localparam [WD_WIDTH-1:0] WD_TOP = {WD_WIDTH{1'b1}};
  localparam [WD_WIDTH-1:0] WD_ONE = {{(WD_WIDTH-1){1'b0}}, 1'b1};

  // prescale limit from the select field, saturating at full depth
  function [PS_W-1:0] presc_limit;
    input [2:0] sel;
    reg [3:0] stages;
    begin
      stages = ({1'b0, sel} > PS_MAX) ? PS_MAX : {1'b0, sel};
      presc_limit = (8'h01 << stages) - 8'h01;
    end
  endfunction

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  wire [2:0] pins_s;
  pmwd_sync #(
    .WIDTH(3),
    .INIT(3'b011)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .din({reset_pin_in, ext_irq_one_pin, ext_irq_zero_pin}),
    .dout(pins_s)
  );
  wire ext_irq_zero_pin_s = pins_s[0];
  wire ext_irq_one_pin_s = pins_s[1];
  wire rst_pin_s = pins_s[2];

  // ----------------------------------------------------------
  // registers and key detection
  // ----------------------------------------------------------
  reg [7:0] power_control_register;
  reg [7:0] watchdog_prescale_select;
  reg [1:0] state;
  reg [7:0] hold_cnt;
  reg hw_reset;
  wire key_wr = sfr_wr && sfr_addr == `PMWD_ADDR_KEY;
  wire key_done;

  pmwd_keyseq u_key (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(key_wr),
    .wr_data(sfr_wdata),
    .key_done(key_done)
  );

  wire general_flag_zero = power_control_register[`PMWD_BIT_GF0];
  wire general_flag_one = power_control_register[`PMWD_BIT_GF1];

  // ----------------------------------------------------------
  // external reset hold: two machine cycles
  // ----------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      hold_cnt <= 8'h00;
      hw_reset <= 1'b0;
    end else if (ce) begin
      hw_reset <= 1'b0;
      if (!rst_pin_s || reset_pin_oe) begin
        hold_cnt <= 8'h00;
      end else if (hold_cnt < HOLD_CYC) begin
        hold_cnt <= hold_cnt + 8'h01;
      end else begin
        hw_reset <= 1'b1; // R6
      end
    end
  end

  // ----------------------------------------------------------
  // watchdog: machine-cycle tick, prescaler, counter
  // ----------------------------------------------------------
  reg wd_en;
  reg [MC_W-1:0] mc_cnt;
  reg [PS_W-1:0] ps_cnt;
  reg [WD_WIDTH-1:0] watchdog_counter;
  reg [7:0] pulse_cnt;
  wire mc_tick = osc_run && mc_cnt == MC_LAST;
  wire ps_tick = mc_tick &&
    ps_cnt >= presc_limit(watchdog_prescale_select[2:0]); // R22
  wire wd_ovf = wd_en && ps_tick &&
    watchdog_counter == WD_TOP; // R16

  always @(posedge mclk) begin
    if (!rst_n) begin
      wd_en <= 1'b0; // R13
      mc_cnt <= {MC_W{1'b0}};
      ps_cnt <= {PS_W{1'b0}};
      watchdog_counter <= {WD_WIDTH{1'b0}};
      pulse_cnt <= 8'h00;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
    end else if (ce) begin
      if (osc_run) begin
        mc_cnt <= mc_tick ? {MC_W{1'b0}} : mc_cnt + 4'h1;
      end
      if (hw_reset || wd_ovf) begin
        wd_en <= 1'b0; // R15
        watchdog_counter <= {WD_WIDTH{1'b0}};
        ps_cnt <= {PS_W{1'b0}};
      end else if (key_done) begin
        wd_en <= 1'b1; // R14
        watchdog_counter <= {WD_WIDTH{1'b0}}; // R16
        ps_cnt <= {PS_W{1'b0}};
      end else if (wd_en && mc_tick) begin
        if (ps_tick) begin
          ps_cnt <= {PS_W{1'b0}}; // R20
          watchdog_counter <= watchdog_counter + WD_ONE; // R15
        end else begin
          ps_cnt <= ps_cnt + 8'h01;
        end
      end
      if (wd_ovf) begin
        reset_pin_out <= 1'b1; // R17
        reset_pin_oe <= 1'b1;
        pulse_cnt <= 8'h00;
      end else if (reset_pin_oe) begin
        if (pulse_cnt == PULSE_LAST) begin
          reset_pin_out <= 1'b0;
          reset_pin_oe <= 1'b0;
        end else begin
          pulse_cnt <= pulse_cnt + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // power control register and mode machine
  // ----------------------------------------------------------
  wire power_control_register_wr = sfr_wr && sfr_addr == `PMWD_ADDR_POWER_CONTROL_REGISTER;
  wire [1:0] wake_low = ~{ext_irq_one_pin_s, ext_irq_zero_pin_s} & ext_irq_enable; // R9
  reg [1:0] wake_seen;
  reg [1:0] next_state;

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        // the setting instruction retires before the mode starts
        if (power_control_register[PD_BIT] && instr_retire) begin
          next_state = ST_PDOWN; // R1
        end else if (power_control_register[`PMWD_BIT_IDLE] &&
            instr_retire) begin
          next_state = ST_IDLE; // R1
        end
      end
      ST_IDLE: begin
        if (irq_pending) begin
          next_state = ST_RUN; // R4
        end
      end
      ST_PDOWN: begin
        if (|wake_low) begin
          next_state = ST_WAKE; // R10
        end
      end
      ST_WAKE: begin
        if (|(wake_seen & ~wake_low)) begin
          next_state = ST_RUN; // R10
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n || hw_reset || wd_ovf) begin
      state <= ST_RUN; // R8
      power_control_register <= `PMWD_POWER_CONTROL_REGISTER_RESET;
      watchdog_prescale_select <= `PMWD_PRESC_RESET;
      wake_seen <= 2'b00;
      wake_vector_one <= 1'b0;
      wake_irq <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      wake_irq <= 1'b0;
      if (power_control_register_wr) begin
        power_control_register <= sfr_wdata; // R5
      end
      if (sfr_wr && sfr_addr == `PMWD_ADDR_PRESC) begin
        watchdog_prescale_select <= sfr_wdata; // R20
      end
      if (state == ST_IDLE && next_state == ST_RUN) begin
        power_control_register[`PMWD_BIT_IDLE] <= 1'b0; // R4
      end
      if (state == ST_PDOWN) begin
        wake_seen <= wake_low;
      end else if (state == ST_WAKE) begin
        wake_seen <= wake_seen | wake_low;
      end
      if (state == ST_WAKE && next_state == ST_RUN) begin
        power_control_register[PD_BIT] <= 1'b0; // R11
        wake_irq <= 1'b1;
        // both seen: higher priority one is serviced
        wake_vector_one <= (wake_seen == 2'b11) ?
          !ext_irq_zero_high_prio : wake_seen[1]; // R10
      end
    end
  end

  // ----------------------------------------------------------
  // mode outputs and register read port
  // ----------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_run <= 1'b1;
      hold_state <= 1'b0;
      ale_force_high <= 1'b0;
      program_store_enable_pin_high <= 1'b0;
      idle_active <= 1'b0;
      pdown_active <= 1'b0;
      device_reset <= 1'b1;
      sfr_rdata <= 8'h00;
      sfr_rvalid <= 1'b0;
    end else if (ce) begin
      cpu_clk_en <= next_state == ST_RUN; // R2
      periph_clk_en <= next_state != ST_PDOWN; // R2
      osc_run <= next_state != ST_PDOWN; // R7
      hold_state <= next_state != ST_RUN; // R3
      ale_force_high <= next_state == ST_IDLE; // R3
      program_store_enable_pin_high <= next_state == ST_IDLE; // R3
      idle_active <= next_state == ST_IDLE;
      pdown_active <= next_state == ST_PDOWN || next_state == ST_WAKE;
      device_reset <= hw_reset || wd_ovf || reset_pin_oe; // R6
      sfr_rvalid <= sfr_rd;
      sfr_rdata <= 8'h00; // R18
      if (sfr_rd && sfr_addr == `PMWD_ADDR_POWER_CONTROL_REGISTER) begin
        sfr_rdata <= power_control_register;
      end else if (sfr_rd && sfr_addr == `PMWD_ADDR_PRESC) begin
        sfr_rdata <= watchdog_prescale_select;
      end
    end
  end
endmodule

//--- logic/pmwd_keyseq.v
`timescale 1ns/1ps
`include "pmwd_map.vh"
// ------------------------------------------------------------
// detects the ordered two-byte key on the service register
// ------------------------------------------------------------
module pmwd_keyseq (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire wr_en,
  input wire [7:0] wr_data,
  output reg key_done
);
  reg armed;

  always @(posedge mclk) begin
    if (!rst_n) begin
      armed <= 1'b0;
      key_done <= 1'b0;
    end else if (ce) begin
      key_done <= 1'b0;
      if (wr_en) begin
        // any other byte breaks the pair
        if (armed && wr_data == `PMWD_KEY_SECOND) begin
          key_done <= 1'b1;
          armed <= 1'b0;
        end else begin
          armed <= (wr_data == `PMWD_KEY_FIRST);
        end
      end
    end
  end
endmodule

//--- logic/pmwd_map.vh
`ifndef PMWD_MAP_VH
`define PMWD_MAP_VH
// special function register addresses
`define PMWD_ADDR_POWER_CONTROL_REGISTER 8'h87
`define PMWD_ADDR_KEY 8'hA6
`define PMWD_ADDR_PRESC 8'hA7
// power control register bit positions
`define PMWD_BIT_IDLE 0
`define PMWD_BIT_PDOWN 1
`define PMWD_BIT_GF0 2
`define PMWD_BIT_GF1 3
// watchdog key bytes
`define PMWD_KEY_FIRST 8'h1E
`define PMWD_KEY_SECOND 8'hE1
// watchdog figures
`define PMWD_WD_WIDTH 14
`define PMWD_WD_TOP 14'h3FFF
`define PMWD_PRESC_BITS 7
`define PMWD_OSC_PER_MC 12
`define PMWD_RST_PULSE_OSC 96
`define PMWD_RST_HOLD_MC 2
// reset values
`define PMWD_POWER_CONTROL_REGISTER_RESET 8'h00
`define PMWD_PRESC_RESET 8'h00
`endif

//--- logic/pmwd_sync.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-stage synchroniser for pin inputs
// ------------------------------------------------------------
module pmwd_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta;

  always @(posedge mclk) begin
    if (!rst_n) begin
      meta <= INIT;
      dout <= INIT;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

//--- verification/pmwd_core_properties.sv
`timescale 1ns/1ps
// ---
// port checks
// ---
module pmwd_core_properties #(
  parameter int PULSE_OSC = 96
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic irq_pending,
  input wire logic [1:0] ext_irq_enable,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  input wire logic cpu_clk_en,
  input wire logic osc_run,
  input wire logic ale_force_high,
  input wire logic program_store_enable_pin_high,
  input wire logic wake_irq,
  input wire logic device_reset,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic idle_active,
  input wire logic pdown_active
);
  logic [7:0] pcnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  always @(posedge mclk) begin
    if (!rst_n || !reset_pin_oe)
      pcnt <= 8'h00;
    else
      pcnt <= pcnt + 8'h01;
  end
  property p_idle; idle_active |-> !cpu_clk_en && osc_run &&
    ale_force_high && program_store_enable_pin_high; endproperty
  property p_wake_idle; idle_active && irq_pending |=> cpu_clk_en;
  endproperty
  property p_pd; pdown_active |-> !cpu_clk_en; endproperty
  property p_no_wake; pdown_active && ext_irq_enable == 2'b00 |=>
    !wake_irq; endproperty
  property p_key_rd; sfr_rd && sfr_addr == 8'hA6 |=>
    sfr_rvalid && sfr_rdata == 8'h00; endproperty
  property p_len; $fell(reset_pin_oe) |-> pcnt == 8'(PULSE_OSC);
  endproperty
  property p_oe; reset_pin_oe |-> reset_pin_out && device_reset;
  endproperty
  property p_clean; $rose(rst_n) |-> !reset_pin_oe [*8]; endproperty
  a_idle: assert property (p_idle)
    else $error("idle outputs wrong");
  a_wake_idle: assert property (p_wake_idle)
    else $error("idle not left on irq");
  a_pd: assert property (p_pd)
    else $error("cpu clocked in power-down");
  a_no_wake: assert property (p_no_wake)
    else $error("wake without enable");
  a_key_rd: assert property (p_key_rd)
    else $error("key register readable");
  a_len: assert property (p_len)
    else $error("reset pulse length wrong");
  a_oe: assert property (p_oe)
    else $error("reset pulse not driven high");
  a_clean: assert property (p_clean)
    else $error("watchdog active after reset");
  c_idle: cover property (idle_active && irq_pending);
  c_wake: cover property (wake_irq);
  c_pulse: cover property ($fell(reset_pin_oe));
endmodule
bind pmwd_core pmwd_core_properties #(.PULSE_OSC(PULSE_OSC)) u_props (
  .mclk(mclk), .rst_n(rst_n), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
  .irq_pending(irq_pending), .ext_irq_enable(ext_irq_enable),
  .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .osc_run(osc_run),
  .cpu_clk_en(cpu_clk_en), .ale_force_high(ale_force_high),
  .program_store_enable_pin_high(program_store_enable_pin_high),
  .wake_irq(wake_irq), .device_reset(device_reset),
  .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
  .idle_active(idle_active), .pdown_active(pdown_active));

//--- verification/pmwd_cpu_model.sv
`timescale 1ns/1ps
// ---
// cpu core and wake pin stand-in
// ---
module pmwd_cpu_model (
  input wire logic mclk,
  input wire logic cpu_clk_en,
  input wire logic osc_run,
  input wire logic want,
  input wire logic wake0,
  output logic instr_retire,
  output logic ext_irq_zero_pin
);
  logic [2:0] held;
  initial begin
    instr_retire = 1'b0;
    ext_irq_zero_pin = 1'b1;
    held = 3'h0;
  end
  // a gated cpu retires nothing; one pulse per request
  always @(negedge mclk) begin
    instr_retire <= want & cpu_clk_en & ~instr_retire;
    if (!wake0)
      held <= 3'h0;
    else if (osc_run && held != 3'h7)
      held <= held + 3'h1;
    ext_irq_zero_pin <= !(wake0 && held < 3'h4);
  end
endmodule

//--- verification/tb_power_modes_watchdog.sv
`timescale 1ns/1ps
`include "pmwd_map.vh"
// ---
// bench
// ---
module tb_power_modes_watchdog;
  localparam int WDW = 8;
  localparam int TO = (1 << WDW) * `PMWD_OSC_PER_MC;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic irq_pending = 1'b0;
  logic want = 1'b0;
  logic wake0 = 1'b0;
  logic rpin = 1'b0;
  logic [1:0] ext_irq_enable = 2'b00;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] r, sfr_rdata;
  logic sfr_rvalid, cpu_clk_en, osc_run, wake_vector_one, wake_irq;
  logic reset_pin_oe, idle_active, instr_retire, irq0_pin;
  logic [7:0] expq[$];
  int err_total = 0;
  int n_tests = 0;
  int n;
  always #10 mclk = ~mclk;
  pmwd_core #(.WD_WIDTH(WDW)) uut (.mclk(mclk), .rst_n(rst_n),
    .ce(1'b1), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .instr_retire(instr_retire),
    .irq_pending(irq_pending), .ext_irq_enable(ext_irq_enable),
    .ext_irq_zero_high_prio(1'b1), .ext_irq_zero_pin(irq0_pin),
    .ext_irq_one_pin(1'b1), .reset_pin_in(rpin), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .cpu_clk_en(cpu_clk_en), .periph_clk_en(),
    .osc_run(osc_run), .hold_state(), .ale_force_high(),
    .program_store_enable_pin_high(), .wake_vector_one(wake_vector_one),
    .wake_irq(wake_irq), .device_reset(), .reset_pin_out(),
    .reset_pin_oe(reset_pin_oe), .idle_active(idle_active),
    .pdown_active());
  pmwd_cpu_model cpu (.mclk(mclk), .cpu_clk_en(cpu_clk_en),
    .osc_run(osc_run), .want(want), .wake0(wake0),
    .instr_retire(instr_retire), .ext_irq_zero_pin(irq0_pin));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (e !== s) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function logic sig(input int w);
    case (w)
      0: sig = cpu_clk_en;
      1: sig = osc_run;
      2: sig = wake_irq;
      default: sig = reset_pin_oe;
    endcase
  endfunction
  task wt(input int w, input logic v, input int lim, input bit must,
      output int k);
    for (k = 0; k < lim && sig(w) !== v; k++) @(negedge mclk);
    if (must && k == lim) begin
      err_total++;
      $display("Error wait_%0d expected %0d seen %0d", w, v, k);
      stop_test;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    expq.push_back(e);
    @(negedge mclk);
    sfr_rd = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task retire;
    @(posedge mclk) want <= 1'b1;
    repeat (2) @(posedge mclk);
    want <= 1'b0;
  endtask
  always @(posedge mclk) begin
    if (sfr_rvalid === 1'b1 && expq.size() > 0)
      chk("sfr_rdata", expq.pop_front(), sfr_rdata);
  end
  initial begin
    r = 8'($urandom(37));
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    rd(`PMWD_ADDR_POWER_CONTROL_REGISTER, `PMWD_POWER_CONTROL_REGISTER_RESET);
    rd(`PMWD_ADDR_PRESC, `PMWD_PRESC_RESET);
    rd(`PMWD_ADDR_KEY, 8'h00);
    rd(8'h55, 8'h00);
    r = 8'($urandom()) & 8'hF8;
    wr(`PMWD_ADDR_PRESC, r);
    rd(`PMWD_ADDR_PRESC, r);
    $display("register test done");
    wr(`PMWD_ADDR_POWER_CONTROL_REGISTER, 8'h0D);
    repeat (3) @(negedge mclk);
    chk("cpu_clk_en", 1'b1, cpu_clk_en);
    retire;
    wt(0, 1'b0, 20, 1'b1, n);
    chk("idle_active", 1'b1, idle_active);
    irq_pending = 1'b1;
    wt(0, 1'b1, 20, 1'b1, n);
    irq_pending = 1'b0;
    rd(`PMWD_ADDR_POWER_CONTROL_REGISTER, 8'h0C);
    $display("idle test done");
    wr(`PMWD_ADDR_POWER_CONTROL_REGISTER, 8'h02);
    retire;
    wt(1, 1'b0, 20, 1'b1, n);
    @(posedge mclk) wake0 <= 1'b1;
    repeat (20) @(negedge mclk);
    chk("osc_run", 1'b0, osc_run);
    ext_irq_enable = 2'b01;
    wt(2, 1'b1, 60, 1'b1, n);
    chk("wake_vector_one", 1'b0, wake_vector_one);
    wake0 <= 1'b0;
    $display("power-down test done");
    wr(`PMWD_ADDR_KEY, `PMWD_KEY_SECOND);
    wt(3, 1'b1, TO + 500, 1'b0, n);
    chk("lone_key", 16'(TO + 500), 16'(n));
    repeat (3) begin
      wr(`PMWD_ADDR_KEY, `PMWD_KEY_FIRST);
      wr(`PMWD_ADDR_KEY, `PMWD_KEY_SECOND);
      wt(3, 1'b1, TO / 2, 1'b0, n);
      chk("serviced", 16'(TO / 2), 16'(n));
    end
    wt(3, 1'b1, TO + 100, 1'b1, n);
    chk("overflow_time", 1'b1, n >= TO / 2 - 12 && n <= TO / 2 + 24);
    wt(3, 1'b0, 200, 1'b1, n);
    wt(3, 1'b1, TO + 100, 1'b0, n);
    chk("off_after", 16'(TO + 100), 16'(n));
    chk("reads_left", 16'h0000, 16'(expq.size()));
    $display("watchdog test done");
    wr(`PMWD_ADDR_POWER_CONTROL_REGISTER, 8'h01);
    retire;
    wt(0, 1'b0, 20, 1'b1, n);
    rpin = 1'b1;
    repeat (30) @(negedge mclk);
    rpin = 1'b0;
    chk("idle_active", 1'b0, idle_active);
    rd(`PMWD_ADDR_POWER_CONTROL_REGISTER, `PMWD_POWER_CONTROL_REGISTER_RESET);
    $display("reset test done");
    stop_test;
  end
endmodule
